// >>> include/embd_defs.svh
// Notes on behaviour
// - Low port carries low address then data during every external access.
// - High port drives upper eight address bits while low port is the bus.
// - Low port driven both ways as bus, open-drain otherwise.
// - Bus used for external fetches, code reads and external data moves.
// - Bus activity counted in machine cycles of four clocks.
// - Data-move access length programmable from two to nine machine cycles.
// - On-chip 1 KB data SRAM sits at data-move addresses 0000H to 03FFH.
// - SRAM range goes to SRAM only while the enable bit is set.
// - Reset clears the enable bit, so all data moves go external.
// - Scratchpad RAM and data SRAM are separate, non-overlapping spaces.
// - Data SRAM serves data moves only, never instruction fetches.
// - External data writes assert the write strobe.
// - External data reads assert the read strobe.
// - Program space has two 64 KB banks for fetches and code reads.
// - Program-store strobe pulses for external code accesses, never internal ones.
// - Address latch strobe lets outside latch the low address byte.
// - With SRAM enabled, data moves above 03FFH still go external.
`ifndef EMBD_DEFS_SVH
`define EMBD_DEFS_SVH
`define EMBD_MC_CLKS 4
`define EMBD_LEN_MIN 2
`define EMBD_FETCH_MC 2
`define EMBD_SRAM_TOP 16'h03FF
`define EMBD_PMR_RST 8'h00
`define EMBD_PMR_XRAM_BIT 0
`define EMBD_PMR_LEN_LSB 1
`define EMBD_PMR_LEN_MSB 3
`define EMBD_ALE_END 2
`define EMBD_ADDR_END 3
`define EMBD_STRB_START 4
`endif

// >>> include/embd_pkg.sv
// ----------------------------------------
// Shared types of the bus decoder
// ----------------------------------------
package embd_pkg;
  typedef enum logic [1:0] {KIND_FETCH, KIND_CODE_RD, KIND_DATA_RD, KIND_DATA_WR} embd_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXT, ST_FIN} embd_state_t;
endpackage : embd_pkg

// >>> logic/embd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "embd_defs.svh"
module embd_top (
  input wire logic i_ref_clk, // 100 MHz clock
  input wire logic i_sys_rst, // Synchronous reset, high
  input wire logic i_clk_en, // Freezes all state when low
  input wire logic i_req, // Access request from core
  input wire embd_pkg::embd_kind_t i_req_kind, // Kind of access
  input wire logic [15:0] i_req_addr, // Access address
  input wire logic [7:0] i_req_wdata, // Write data
  input wire logic i_prog_bank, // Program bank select
  input wire logic i_pmr_wr, // Write strobe for power management reg
  input wire logic [7:0] i_pmr_wdata, // Power management reg write data
  input wire logic [7:0] i_int_code_data, // Internal program memory data
  input wire logic i_ext_access_sel, // Access select pin, low = external code
  input wire logic [7:0] i_ad_in, // Low port pin levels
  input wire logic [7:0] i_p0_latch, // Low port latch for plain I/O use
  input wire logic [7:0] i_p2_latch, // High port latch for plain I/O use
  output logic o_ready, // Idle, request may be made
  output logic o_done, // Access finished, one cycle
  output logic [7:0] o_rdata, // Read data, valid with o_done
  output logic [7:0] o_pmr, // Power management reg readback
  output logic [7:0] o_ad_out, // Low port output levels
  output logic [7:0] o_ad_oe, // Low port output enables
  output logic [7:0] o_addr_hi, // High port levels
  output logic o_addr_bank, // Program bank address line
  output logic o_ale, // Address latch strobe, high
  output logic o_program_store_strobe_n, // Program store strobe, low
  output logic o_rd_n, // Data read strobe, low
  output logic o_wr_n // Data write strobe, low
);
  import embd_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  embd_state_t st_reg;
  embd_kind_t kind_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic bank_reg;
  logic ext_reg;
  logic [5:0] cnt_reg;
  logic [5:0] last_reg;
  logic [7:0] pmr_reg;
  logic ea_s1_reg, ea_s2_reg;
  logic [7:0] ad_s1_reg, ad_s2_reg;
  logic [7:0] sram_mem [0:1023];
  logic req_prog, req_onchip, req_internal, req_local, ext_last, kind_prog;
  logic [3:0] len_mc;
  logic [5:0] last_next;
  logic [7:0] ad_out_next, ad_oe_next, addr_hi_next;
  logic bank_next, ale_next, program_store_strobe_n_next, rd_n_next, wr_n_next;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Access select and bus data come from outside the clock domain
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ea_s1_reg <= 1'b1;
      ea_s2_reg <= 1'b1;
      ad_s1_reg <= 8'h00;
      ad_s2_reg <= 8'h00;
    end
    else if (i_clk_en)
    begin
      ea_s1_reg <= i_ext_access_sel;
      ea_s2_reg <= ea_s1_reg;
      ad_s1_reg <= i_ad_in;
      ad_s2_reg <= ad_s1_reg;
    end
  end

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  // Code kinds never reach the data SRAM; scratchpad is not in this space at all
  assign req_prog = (i_req_kind == KIND_FETCH) || (i_req_kind == KIND_CODE_RD);
  // SRAM hit only when enabled and at or below the top address
  assign req_onchip = pmr_reg[`EMBD_PMR_XRAM_BIT] && !req_prog
                      && (i_req_addr <= `EMBD_SRAM_TOP);
  // Access select high keeps code accesses internal
  assign req_internal = req_prog && ea_s2_reg;
  assign req_local = req_onchip || req_internal;
  // Programmed length for data moves, fixed length for code
  assign len_mc = req_prog ? 4'(`EMBD_FETCH_MC)
                  : 4'(pmr_reg[`EMBD_PMR_LEN_MSB:`EMBD_PMR_LEN_LSB]) + 4'(`EMBD_LEN_MIN);
  assign last_next = 6'(len_mc) * 6'(`EMBD_MC_CLKS) - 6'd1;
  assign ext_last = (st_reg == ST_EXT) && (cnt_reg == last_reg);
  assign kind_prog = (kind_reg == KIND_FETCH) || (kind_reg == KIND_CODE_RD);

  // ----------------------------------------
  // Power management register
  // ----------------------------------------
  // Enable bit and length field; reset sends all data moves off chip
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      pmr_reg <= `EMBD_PMR_RST;
    else if (i_clk_en && i_pmr_wr)
      pmr_reg <= i_pmr_wdata;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  // Local accesses finish at once, external ones walk the bus cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      st_reg <= ST_IDLE;
    else if (i_clk_en)
    begin
      unique case (st_reg)
        ST_IDLE:
        begin
          if (i_req)
            st_reg <= req_local ? ST_FIN : ST_EXT;
        end
        ST_EXT:
        begin
          if (cnt_reg == last_reg)
            st_reg <= ST_FIN;
        end
        ST_FIN:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // Request capture and clock counter within the access
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      kind_reg <= KIND_FETCH;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      bank_reg <= 1'b0;
      ext_reg <= 1'b0;
      last_reg <= 6'h00;
      cnt_reg <= 6'h00;
    end
    else if (i_clk_en)
    begin
      if (st_reg == ST_IDLE && i_req)
      begin
        kind_reg <= i_req_kind;
        addr_reg <= i_req_addr;
        wdata_reg <= i_req_wdata;
        bank_reg <= i_prog_bank;
        ext_reg <= !req_local;
        last_reg <= last_next;
      end
      cnt_reg <= (st_reg == ST_EXT) ? cnt_reg + 6'd1 : 6'h00;
    end
  end

  // ----------------------------------------
  // On-chip data SRAM
  // ----------------------------------------
  // Single cycle write for data moves that hit the enabled range
  always_ff @(posedge i_ref_clk)
  begin
    if (i_clk_en && st_reg == ST_IDLE && i_req && req_onchip && i_req_kind == KIND_DATA_WR)
      sram_mem[i_req_addr[9:0]] <= i_req_wdata;
  end

  // ----------------------------------------
  // Completion and read data
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_ready <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_done <= (st_reg == ST_IDLE && i_req && req_local) || ext_last;
      o_ready <= (st_reg == ST_FIN) || (st_reg == ST_IDLE && !i_req);
      if (st_reg == ST_IDLE && i_req && req_onchip)
        o_rdata <= sram_mem[i_req_addr[9:0]];
      else if (st_reg == ST_IDLE && i_req && req_internal)
        o_rdata <= i_int_code_data;
      else if (ext_last && kind_reg != KIND_DATA_WR)
        o_rdata <= ad_s2_reg;
    end
  end

  // ----------------------------------------
  // Bus pin values
  // ----------------------------------------
  // Address phase, then data phase, strobes in the tail of the access
  always_comb
  begin
    ad_out_next = 8'h00;
    ad_oe_next = ~i_p0_latch;
    addr_hi_next = i_p2_latch;
    bank_next = 1'b0;
    ale_next = 1'b0;
    program_store_strobe_n_next = 1'b1;
    rd_n_next = 1'b1;
    wr_n_next = 1'b1;
    if (st_reg == ST_EXT)
    begin
      addr_hi_next = addr_reg[15:8];
      bank_next = kind_prog ? bank_reg : 1'b0;
      ad_oe_next = 8'hFF;
      ale_next = (cnt_reg < 6'(`EMBD_ALE_END));
      if (cnt_reg < 6'(`EMBD_ADDR_END))
        ad_out_next = addr_reg[7:0];
      else if (kind_reg == KIND_DATA_WR)
        ad_out_next = wdata_reg;
      else
        ad_oe_next = 8'h00;
      if (cnt_reg >= 6'(`EMBD_STRB_START))
      begin
        program_store_strobe_n_next = !kind_prog;
        rd_n_next = (kind_reg != KIND_DATA_RD);
        wr_n_next = (kind_reg != KIND_DATA_WR);
      end
    end
    else if (st_reg == ST_FIN && ext_reg && kind_reg == KIND_DATA_WR)
    begin
      addr_hi_next = addr_reg[15:8];
      ad_out_next = wdata_reg;
      ad_oe_next = 8'hFF;
    end
  end

  // Every pin leaves from a flip-flop
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_ad_out <= 8'h00;
      o_ad_oe <= 8'h00;
      o_addr_hi <= 8'h00;
      o_addr_bank <= 1'b0;
      o_ale <= 1'b0;
      o_program_store_strobe_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
    end
    else if (i_clk_en)
    begin
      o_ad_out <= ad_out_next;
      o_ad_oe <= ad_oe_next;
      o_addr_hi <= addr_hi_next;
      o_addr_bank <= bank_next;
      o_ale <= ale_next;
      o_program_store_strobe_n <= program_store_strobe_n_next;
      o_rd_n <= rd_n_next;
      o_wr_n <= wr_n_next;
    end
  end

  assign o_pmr = pmr_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [6:0] ext_clks_reg;
  logic [6:0] len_clks_reg;
  // Counts clocks spent in the external phase
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst || st_reg == ST_IDLE)
      ext_clks_reg <= 7'h00;
    else if (i_clk_en && st_reg == ST_EXT)
      ext_clks_reg <= ext_clks_reg + 7'd1;
  end
  // Expected data-move length captured from the field at accept time
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      len_clks_reg <= 7'h00;
    else if (i_clk_en && st_reg == ST_IDLE && i_req)
      len_clks_reg <= (7'(pmr_reg[`EMBD_PMR_LEN_MSB:`EMBD_PMR_LEN_LSB]) + 7'(`EMBD_LEN_MIN))
                      * 7'(`EMBD_MC_CLKS);
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst || !i_clk_en);

  a_addr_mux: assert property ($fell(o_ale) |-> o_ad_out == addr_reg[7:0] ##1 o_ad_out != addr_reg[7:0] || o_ad_oe == 8'h00 || o_ad_out == wdata_reg)
    else $error("low address not held past latch strobe");
  a_hi_addr: assert property (o_ale |-> o_addr_hi == addr_reg[15:8])
    else $error("upper address missing during latch strobe");
  a_strong_drive: assert property (o_ale |-> o_ad_oe == 8'hFF)
    else $error("low port not fully driven in address phase");
  a_data_len: assert property ($rose(o_done) && ext_reg && !kind_prog |-> ext_clks_reg == len_clks_reg)
    else $error("external data move length wrong");
  a_fetch_len: assert property ($rose(o_done) && ext_reg && kind_prog |-> ext_clks_reg == 7'd8)
    else $error("external code access not two machine cycles");
  a_reset_ext: assert property ($past(i_sys_rst) |-> !pmr_reg[`EMBD_PMR_XRAM_BIT])
    else $error("SRAM enable set after reset");
  a_sram_quiet: assert property (st_reg == ST_IDLE && i_req && req_onchip |-> ##1 (!o_ale && o_rd_n && o_wr_n)[*2])
    else $error("bus strobes on SRAM access");
  a_sram_fast: assert property (st_reg == ST_IDLE && i_req && req_onchip |=> o_done)
    else $error("SRAM access not single cycle");
  a_program_store_strobe_internal: assert property (st_reg == ST_IDLE && i_req && req_internal |-> ##1 o_program_store_strobe_n[*3])
    else $error("program strobe on internal access");
  a_wr_kind: assert property (!o_wr_n |-> kind_reg == KIND_DATA_WR && o_program_store_strobe_n && o_rd_n)
    else $error("write strobe on wrong access");
  a_rd_kind: assert property (!o_rd_n |-> kind_reg == KIND_DATA_RD && o_ad_oe == 8'h00)
    else $error("read strobe while driving bus");

  c_ext_write: cover property (!o_wr_n ##1 o_wr_n);
  c_ext_read: cover property (!o_rd_n ##1 o_rd_n);
  c_sram_read: cover property (st_reg == ST_IDLE && i_req && req_onchip && i_req_kind == KIND_DATA_RD);
  c_ext_fetch: cover property (!o_program_store_strobe_n && o_addr_bank);
endmodule : embd_top
`default_nettype wire

// >>> tb/embd_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module embd_ext_mem (
  input wire logic i_clk, // Bench clock
  input wire logic [7:0] i_ad_out, // Low port levels from device
  input wire logic [7:0] i_ad_oe, // Low port enables from device
  input wire logic [7:0] i_addr_hi, // High address port
  input wire logic i_addr_bank, // Program bank line
  input wire logic i_ale, // Address latch strobe
  input wire logic i_program_store_strobe_n, // Program store strobe
  input wire logic i_rd_n, // Data read strobe
  input wire logic i_wr_n, // Data write strobe
  output logic [7:0] o_ad_level // Resolved low port wire
);
  logic [7:0] code_mem [0:131071];
  logic [7:0] data_mem [0:65535];
  logic [15:0] addr_q;
  logic bank_q;
  logic [7:0] last_reg = 8'h00;
  logic drv_en;
  logic [7:0] drive;
  // Known contents so the bench can predict reads
  initial
  begin
    for (int a = 0; a < 65536; a++)
    begin
      data_mem[a] = a[7:0] ^ a[15:8] ^ 8'h5A;
      code_mem[a] = a[7:0] + a[15:8];
      code_mem[a + 65536] = (a[7:0] + a[15:8]) ^ 8'h33;
    end
  end
  // Latch address as the latch strobe falls
  always @(negedge i_ale)
  begin
    addr_q = {i_addr_hi, o_ad_level};
    bank_q = i_addr_bank;
  end
  // Store data as the write strobe is released
  always @(posedge i_wr_n)
  begin
    data_mem[addr_q] = o_ad_level;
  end
  // Undriven bits never keep their old level
  always @(posedge i_clk)
  begin
    last_reg <= o_ad_level;
  end
  assign drv_en = !i_program_store_strobe_n || !i_rd_n;
  assign drive = !i_program_store_strobe_n ? code_mem[{bank_q, addr_q}] : data_mem[addr_q];
  assign o_ad_level = (i_ad_oe & i_ad_out) | (~i_ad_oe & (drv_en ? drive : ~last_reg));
endmodule : embd_ext_mem
`default_nettype wire

// >>> tb/external_memory_bus_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_decode_test;
  import embd_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_req = 1'b0;
  embd_kind_t i_req_kind = KIND_FETCH;
  logic [15:0] i_req_addr = 16'h0000;
  logic [7:0] i_req_wdata = 8'h00;
  logic i_prog_bank = 1'b0;
  logic i_pmr_wr = 1'b0;
  logic [7:0] i_pmr_wdata = 8'h00;
  logic [7:0] i_int_code_data = 8'h00;
  logic i_ext_access_sel = 1'b1;
  logic [7:0] i_p0_latch = 8'hA5;
  logic [7:0] i_p2_latch = 8'h3C;
  logic o_ready, o_done, o_addr_bank, o_ale, o_program_store_strobe_n, o_rd_n, o_wr_n;
  logic [7:0] o_rdata, o_pmr, o_ad_out, o_ad_oe, o_addr_hi, ad_level;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] pmr_shadow = 8'h00;
  // ----------------------------------------
  // Device and far side
  // ----------------------------------------
  embd_top dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_req(i_req),
    .i_req_kind(i_req_kind), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .i_prog_bank(i_prog_bank), .i_pmr_wr(i_pmr_wr), .i_pmr_wdata(i_pmr_wdata),
    .i_int_code_data(i_int_code_data), .i_ext_access_sel(i_ext_access_sel),
    .i_ad_in(ad_level), .i_p0_latch(i_p0_latch), .i_p2_latch(i_p2_latch), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_pmr(o_pmr), .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe),
    .o_addr_hi(o_addr_hi), .o_addr_bank(o_addr_bank), .o_ale(o_ale), .o_program_store_strobe_n(o_program_store_strobe_n),
    .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));
  embd_ext_mem mem_u (.i_clk(i_ref_clk), .i_ad_out(o_ad_out), .i_ad_oe(o_ad_oe),
    .i_addr_hi(o_addr_hi), .i_addr_bank(o_addr_bank), .i_ale(o_ale), .i_program_store_strobe_n(o_program_store_strobe_n),
    .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .o_ad_level(ad_level));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end
  function automatic logic [7:0] dpat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : dpat
  function automatic logic [7:0] cpat(input logic b, input logic [15:0] a);
    return (a[7:0] + a[15:8]) ^ (b ? 8'h33 : 8'h00);
  endfunction : cpat
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic set_pmr(input logic [7:0] v);
    @(negedge i_ref_clk);
    i_pmr_wr = 1'b1;
    i_pmr_wdata = v;
    @(negedge i_ref_clk);
    i_pmr_wr = 1'b0;
    pmr_shadow = v;
    chk("pmr", {8'h00, v}, {8'h00, o_pmr});
  endtask : set_pmr
  task automatic idle_chk();
    repeat (3) @(negedge i_ref_clk);
    chk("idle low port enables", {8'h00, ~i_p0_latch}, {8'h00, o_ad_oe});
    chk("idle high port", {8'h00, i_p2_latch}, {8'h00, o_addr_hi});
    chk("ready", 16'h0001, {15'h0000, o_ready});
  endtask : idle_chk
  // One request held until done, with monitor of the pins
  task automatic access(input embd_kind_t k, input logic [15:0] a, input logic [7:0] wd,
    input logic bank, input logic ext, input logic [7:0] exp_rd);
    logic [3:0] seen;
    logic [3:0] exp_s;
    logic bad;
    logic code;
    int n;
    int exp_n;
    seen = 4'h0;
    bad = 1'b0;
    n = 0;
    code = (k == KIND_FETCH) || (k == KIND_CODE_RD);
    exp_s = {ext, ext & code, ext & (k == KIND_DATA_RD), ext & (k == KIND_DATA_WR)};
    exp_n = 1 + (!ext ? 0 : (code ? 8 : 4 * (pmr_shadow[3:1] + 2)));
    @(negedge i_ref_clk);
    i_req = 1'b1;
    i_req_kind = k;
    i_req_addr = a;
    i_req_wdata = wd;
    i_prog_bank = bank;
    do
    begin
      @(negedge i_ref_clk);
      n++;
      seen |= {o_ale, ~o_program_store_strobe_n, ~o_rd_n, ~o_wr_n};
      if (o_ale && (o_ad_oe !== 8'hFF || o_ad_out !== a[7:0] || o_addr_hi !== a[15:8]))
        bad = 1'b1;
      if (o_ale && code && o_addr_bank !== bank)
        bad = 1'b1;
    end while (o_done !== 1'b1 && n < 64);
    i_req = 1'b0;
    chk("access cycles", exp_n[15:0], n[15:0]);
    chk("strobes", {12'h000, exp_s}, {12'h000, seen});
    chk("address phase", 16'h0000, {15'h0000, bad});
    if (k != KIND_DATA_WR)
      chk("read data", {8'h00, exp_rd}, {8'h00, o_rdata});
  endtask : access
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [15:0] a;
    logic [7:0] wd;
    int unsigned seed_v;
    seed_v = $urandom(94);
    repeat (2) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    chk("reset pmr", 16'h0000, {8'h00, o_pmr});
    idle_chk();
    access(KIND_DATA_RD, 16'h0010, 8'h00, 1'b0, 1'b1, dpat(16'h0010));
    $display("test reset done");
    for (int l = 0; l < 8; l++)
    begin
      set_pmr({4'h0, l[2:0], 1'b0});
      a = (l == 7) ? 16'hFFFF : (16'h0800 | 16'($urandom()));
      wd = 8'($urandom());
      access(KIND_DATA_WR, a, wd, 1'b0, 1'b1, 8'h00);
      access(KIND_DATA_RD, a, 8'h00, 1'b0, 1'b1, wd);
    end
    idle_chk();
    $display("test lengths done");
    set_pmr(8'hF1);
    access(KIND_DATA_WR, 16'h03FF, 8'hC3, 1'b0, 1'b0, 8'h00);
    access(KIND_DATA_RD, 16'h03FF, 8'h00, 1'b0, 1'b0, 8'hC3);
    access(KIND_DATA_WR, 16'h0000, 8'h96, 1'b0, 1'b0, 8'h00);
    access(KIND_DATA_RD, 16'h0000, 8'h00, 1'b0, 1'b0, 8'h96);
    access(KIND_DATA_RD, 16'h0400, 8'h00, 1'b0, 1'b1, dpat(16'h0400));
    set_pmr(8'h00);
    access(KIND_DATA_RD, 16'h03FF, 8'h00, 1'b0, 1'b1, dpat(16'h03FF));
    $display("test sram done");
    i_int_code_data = 8'($urandom());
    access(KIND_FETCH, 16'h1234, 8'h00, 1'b0, 1'b0, i_int_code_data);
    access(KIND_CODE_RD, 16'h0010, 8'h00, 1'b1, 1'b0, i_int_code_data);
    i_ext_access_sel = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    set_pmr(8'h01);
    for (int b = 0; b < 2; b++)
    begin
      a = 16'($urandom());
      access(KIND_FETCH, a, 8'h00, b[0], 1'b1, cpat(b[0], a));
      access(KIND_CODE_RD, 16'h0010, 8'h00, b[0], 1'b1, cpat(b[0], 16'h0010));
    end
    idle_chk();
    $display("test code done");
    // A request made while the clock enable is low is never taken
    @(negedge i_ref_clk);
    i_clk_en = 1'b0;
    i_req = 1'b1;
    i_req_kind = KIND_DATA_WR;
    i_req_addr = 16'h8000;
    repeat (4) @(negedge i_ref_clk);
    chk("frozen high port", {8'h00, i_p2_latch}, {8'h00, o_addr_hi});
    chk("frozen low port enables", {8'h00, ~i_p0_latch}, {8'h00, o_ad_oe});
    i_req = 1'b0;
    i_clk_en = 1'b1;
    idle_chk();
    $display("test freeze done");
    close_out();
  end
endmodule : external_memory_bus_decode_test
`default_nettype wire
